//--- verilog/sfs_regs.svh
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH

// Command opcodes
`define SFS_OP_PERSIST_WE 8'h06
`define SFS_OP_LIVE_WE 8'h50
`define SFS_OP_WR_DISABLE 8'h04
`define SFS_OP_WR_REGS 8'h01
`define SFS_OP_WR_ANY 8'h71
`define SFS_OP_RD_ANY 8'h65
`define SFS_OP_RD_STAT1 8'h05
`define SFS_OP_CLR_STAT 8'h30
`define SFS_OP_SUSPEND 8'h75
`define SFS_OP_RESET_ARM 8'h66
`define SFS_OP_RESET_GO 8'h99
`define SFS_OP_PAGE_PROG 8'h02
`define SFS_OP_SECT_ERASE 8'h20
`define SFS_OP_CHIP_ERASE 8'h60

// Register addresses for write-any and read-any
`define SFS_ADDR_PERSIST 24'h000000
`define SFS_ADDR_LIVE 24'h800000
`define SFS_ADDR_PERSIST_HI 8'h00
`define SFS_ADDR_LIVE_HI 8'h80
`define SFS_ADDR_LOW 8'h00

// Status byte field positions
`define SFS_BIT_LOCK 7
`define SFS_BIT_TOP_BOTTOM 6
`define SFS_BIT_BP_HI 5
`define SFS_BIT_BP_LO 2
`define SFS_BIT_WEL 1
`define SFS_BIT_BUSY 0

// Reset and factory values
`define SFS_FIELD_RESET 6'h00
`define SFS_WEL_DEFAULT 1'b0
`define SFS_BUSY_DEFAULT 1'b0
`define SFS_STATUS_RESET 8'h00

// Duration of a persistent register write in clock cycles
`define SFS_NV_WRITE_CYCLES 16'h0040

`endif

//--- verilog/sfs_pkg.sv
package sfs_pkg;

	typedef enum logic [1:0] {
		SFS_IDLE = 2'b00,
		SFS_NV_WRITE = 2'b01,
		SFS_ARRAY = 2'b11,
		SFS_ERROR = 2'b10
	} sfs_state_t;

endpackage

//--- verilog/sfs_status_one.sv
`timescale 1ns/1ps
`include "sfs_regs.svh"
// Operation
// RULE1 - Persistent lock, side, protect bits user writable
// RULE2 - Persistent bits 1:0 factory fixed, read only
// RULE3 - Lock set and pin low blocks register writes
// RULE4 - Lock clear or pin high allows writes
// RULE5 - Pin affects only status/config register writes
// RULE6 - Live bits follow new persistent values
// RULE7 - Quad modes force internal protect level high
// RULE8 - Side bit picks top or bottom reference
// RULE9 - Protect bits select guarded array portion
// RULE10 - Writes, programs, erases need latch set
// RULE11 - Latch changed only by enable/disable/clear commands
// RULE12 - Successful completion clears the latch
// RULE13 - Host clears latch after failure
// RULE14 - Resets load latch from factory default
// RULE15 - Register writes leave latch and busy alone
// RULE16 - Busy flag reflects running embedded operation
// RULE17 - While busy only listed commands accepted
// RULE18 - Suspend accepted only during array operation
// RULE19 - Error holds busy until clear status; the code also releases busy on soft reset
// RULE20 - Status read returns live register
// RULE21 - Resets copy persistent into live
// RULE22 - Any read delivers the live version
// RULE23 - Error flags cleared only by clear status; the code also clears them on soft reset
module sfs_status_one
	import sfs_pkg::*;
#(
	parameter logic [15:0] NV_WRITE_CYCLES = `SFS_NV_WRITE_CYCLES
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	input wire logic wp_n_i,
	input wire logic quad_command_mode_i,
	input wire logic quad_io_i,
	input wire logic op_done_i,
	input wire logic op_fail_i,
	output logic so_o,
	output logic so_oe_n_o,
	output logic busy_o,
	output logic write_enable_latch_o,
	output logic register_lock_bit_o,
	output logic top_bottom_ref_o,
	output logic [3:0] block_protect_field_o,
	output logic array_start_o,
	output logic array_is_erase_o,
	output logic suspend_o,
	output logic erase_error_o,
	output logic program_error_o
);

	// Link side, clocked by the serial clock
	logic frame_idle;
	logic [2:0] lk_bit_cnt_reg;
	logic [6:0] lk_shift_reg;
	logic [2:0] lk_byte_idx_reg;
	logic [7:0] lk_opcode_reg;
	logic lk_addr_ok_reg;
	logic [7:0] lk_out_reg;
	logic lk_out_en_reg;
	logic [7:0] lk_rx_byte;
	logic lk_byte_done;
	logic lk_tog_reg;
	logic [7:0] lk_data_reg;
	logic lk_req_s1;
	logic lk_req_s2;
	logic lk_ack_reg;
	logic [7:0] lk_mirror_reg;
	logic lk_stat_hit;
	logic lk_any_hit;
	logic pub_req_reg;
	logic [7:0] pub_data_reg;

	assign frame_idle = cs_n_i | ~reset_n_i;
	assign lk_rx_byte = {lk_shift_reg, si_i};
	assign lk_byte_done = lk_bit_cnt_reg == 3'd7;

	always_ff @(posedge sck_i or posedge frame_idle) begin
		if (frame_idle) begin
			lk_bit_cnt_reg <= 3'd0;
			lk_shift_reg <= 7'h00;
			lk_byte_idx_reg <= 3'd0;
		end else begin
			lk_bit_cnt_reg <= lk_bit_cnt_reg + 3'd1;
			lk_shift_reg <= lk_rx_byte[6:0];
			if (lk_byte_done && lk_byte_idx_reg != 3'd7) begin
				lk_byte_idx_reg <= lk_byte_idx_reg + 3'd1;
			end
		end
	end

	always_comb begin
		lk_stat_hit = (lk_byte_idx_reg == 3'd0) ? (lk_rx_byte == `SFS_OP_RD_STAT1) :
			(lk_opcode_reg == `SFS_OP_RD_STAT1);
		lk_any_hit = 1'b0;
		if (lk_opcode_reg == `SFS_OP_RD_ANY) begin
			if (lk_byte_idx_reg == 3'd3) begin
				lk_any_hit = lk_addr_ok_reg && lk_rx_byte == `SFS_ADDR_LOW;
			end else if (lk_byte_idx_reg > 3'd3) begin
				lk_any_hit = lk_addr_ok_reg;
			end
		end
	end

	// Opcode, address match and reply byte for reads
	always_ff @(posedge sck_i or posedge frame_idle) begin
		if (frame_idle) begin
			lk_opcode_reg <= 8'h00;
			lk_addr_ok_reg <= 1'b0;
			lk_out_reg <= 8'h00;
			lk_out_en_reg <= 1'b0;
		end else if (lk_byte_done) begin
			if (lk_byte_idx_reg == 3'd0) begin
				lk_opcode_reg <= lk_rx_byte;
			end else if (lk_byte_idx_reg == 3'd1) begin
				lk_addr_ok_reg <= lk_rx_byte == `SFS_ADDR_PERSIST_HI ||
					lk_rx_byte == `SFS_ADDR_LIVE_HI;
			end else if (lk_byte_idx_reg == 3'd2) begin
				lk_addr_ok_reg <= lk_addr_ok_reg && lk_rx_byte == `SFS_ADDR_LOW;
			end
			if (lk_stat_hit || lk_any_hit) begin
				lk_out_reg <= lk_mirror_reg; // RULE20 RULE22
				lk_out_en_reg <= 1'b1;
			end
		end
	end

	// Completed bytes handed to the core by toggle
	always_ff @(posedge sck_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lk_tog_reg <= 1'b0;
			lk_data_reg <= 8'h00;
		end else if (lk_byte_done && !cs_n_i) begin
			lk_tog_reg <= ~lk_tog_reg;
			lk_data_reg <= lk_rx_byte;
		end
	end

	// Status mirror taken over from the core by handshake
	always_ff @(posedge sck_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lk_req_s1 <= 1'b0;
			lk_req_s2 <= 1'b0;
			lk_ack_reg <= 1'b0;
			lk_mirror_reg <= `SFS_STATUS_RESET;
		end else begin
			lk_req_s1 <= pub_req_reg;
			lk_req_s2 <= lk_req_s1;
			if (lk_req_s2 != lk_ack_reg) begin
				lk_mirror_reg <= pub_data_reg;
				lk_ack_reg <= lk_req_s2;
			end
		end
	end

	// Reply bits change on the falling edge
	always_ff @(negedge sck_i or posedge frame_idle) begin
		if (frame_idle) begin
			so_o <= 1'b0;
			so_oe_n_o <= 1'b1;
		end else begin
			so_o <= lk_out_reg[~lk_bit_cnt_reg];
			so_oe_n_o <= ~lk_out_en_reg;
		end
	end

	// Core side
	logic cs_s1, cs_s2, cs_s3;
	logic tog_s1, tog_s2, tog_s3;
	logic wp_s1, wp_s2;
	logic ack_s1, ack_s2;
	logic frame_end;
	logic byte_new;
	logic [7:0] opcode_reg;
	logic [7:0] arg_reg [0:3];
	logic [2:0] nbytes_reg;
	logic [2:0] arg_idx;
	logic [23:0] arg_addr;
	sfs_state_t state_reg;
	sfs_state_t state_next;
	logic [15:0] nv_timer_reg;
	logic [5:0] nv_pend_reg;
	logic [7:0] persist_reg;
	logic [5:0] field_reg;
	logic wel_reg;
	logic vol_mode_reg;
	logic arm_reg;
	logic arr_erase_reg;
	logic wp_level;
	logic locked;
	logic busy;
	logic nv_finish;
	logic arr_finish;
	logic set_wel, clr_wel, vol_on, vol_off, start_nv, live_wr, start_arr, arr_erase;
	logic susp, clear_status_cmd, soft_rst;
	logic [5:0] wr_field;
	logic [7:0] status_byte;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
			wp_s1 <= 1'b1;
			wp_s2 <= 1'b1;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			cs_s1 <= cs_n_i;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			tog_s1 <= lk_tog_reg;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			wp_s1 <= wp_n_i;
			wp_s2 <= wp_s1;
			ack_s1 <= lk_ack_reg;
			ack_s2 <= ack_s1;
		end
	end

	assign frame_end = cs_s2 & ~cs_s3;
	assign byte_new = tog_s2 ^ tog_s3;
	assign arg_idx = nbytes_reg - 3'd1;
	assign arg_addr = {arg_reg[0], arg_reg[1], arg_reg[2]};
	assign busy = state_reg != SFS_IDLE;
	assign wp_level = wp_s2 | quad_command_mode_i | quad_io_i; // RULE7
	assign locked = field_reg[5] & ~wp_level; // RULE3 RULE4 RULE5
	assign nv_finish = state_reg == SFS_NV_WRITE && nv_timer_reg == 16'h0000;
	assign arr_finish = state_reg == SFS_ARRAY && op_done_i;

	// Bytes of the current frame
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			opcode_reg <= 8'h00;
			nbytes_reg <= 3'd0;
			for (int i = 0; i < 4; i++) begin
				arg_reg[i] <= 8'h00;
			end
		end else if (frame_end) begin
			nbytes_reg <= 3'd0;
		end else if (byte_new) begin
			if (nbytes_reg == 3'd0) begin
				opcode_reg <= lk_data_reg;
			end else if (nbytes_reg <= 3'd4) begin
				arg_reg[arg_idx[1:0]] <= lk_data_reg;
			end
			if (nbytes_reg != 3'd7) begin
				nbytes_reg <= nbytes_reg + 3'd1;
			end
		end
	end

	// Command execution at frame end
	always_comb begin
		set_wel = 1'b0;
		clr_wel = 1'b0;
		vol_on = 1'b0;
		vol_off = 1'b0;
		start_nv = 1'b0;
		live_wr = 1'b0;
		start_arr = 1'b0;
		arr_erase = 1'b0;
		susp = 1'b0;
		clear_status_cmd = 1'b0;
		soft_rst = 1'b0;
		wr_field = arg_reg[0][7:2]; // RULE15
		if (frame_end) begin
			if (opcode_reg == `SFS_OP_CLR_STAT) begin
				clear_status_cmd = 1'b1;
			end else if (opcode_reg == `SFS_OP_SUSPEND) begin
				susp = state_reg == SFS_ARRAY; // RULE18
			end else if (opcode_reg == `SFS_OP_RESET_GO) begin
				soft_rst = arm_reg;
			end else if (!busy) begin // RULE17
				case (opcode_reg)
					`SFS_OP_PERSIST_WE: begin
						set_wel = 1'b1;
						vol_off = 1'b1;
					end
					`SFS_OP_LIVE_WE: begin
						set_wel = 1'b1;
						vol_on = 1'b1;
					end
					`SFS_OP_WR_DISABLE: clr_wel = 1'b1;
					`SFS_OP_WR_REGS: begin
						if (nbytes_reg >= 3'd2 && wel_reg && !locked) begin // RULE10 RULE3
							live_wr = vol_mode_reg;
							start_nv = ~vol_mode_reg;
						end
					end
					`SFS_OP_WR_ANY: begin
						wr_field = arg_reg[3][7:2];
						if (nbytes_reg >= 3'd5 && wel_reg && !locked) begin // RULE10 RULE3
							if (arg_addr == `SFS_ADDR_PERSIST) begin
								start_nv = 1'b1;
							end else if (arg_addr == `SFS_ADDR_LIVE) begin
								live_wr = 1'b1;
							end
						end
					end
					`SFS_OP_PAGE_PROG: start_arr = wel_reg; // RULE10
					`SFS_OP_SECT_ERASE, `SFS_OP_CHIP_ERASE: begin
						start_arr = wel_reg; // RULE10
						arr_erase = 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SFS_IDLE: begin
				if (start_nv) begin
					state_next = SFS_NV_WRITE;
				end else if (start_arr) begin
					state_next = SFS_ARRAY;
				end
			end
			SFS_NV_WRITE: begin
				if (nv_finish) begin
					state_next = SFS_IDLE;
				end
			end
			SFS_ARRAY: begin
				if (op_done_i) begin
					state_next = op_fail_i ? SFS_ERROR : SFS_IDLE; // RULE19
				end
			end
			SFS_ERROR: begin
				if (clear_status_cmd) begin
					state_next = SFS_IDLE; // RULE19
				end
			end
			default: state_next = SFS_IDLE;
		endcase
		if (soft_rst) begin
			state_next = SFS_IDLE;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= SFS_IDLE;
			busy_o <= `SFS_BUSY_DEFAULT;
		end else begin
			state_reg <= state_next;
			busy_o <= state_next != SFS_IDLE; // RULE16
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			nv_timer_reg <= 16'h0000;
			nv_pend_reg <= `SFS_FIELD_RESET;
		end else if (start_nv) begin
			nv_timer_reg <= NV_WRITE_CYCLES - 16'h0001;
			nv_pend_reg <= wr_field;
		end else if (state_reg == SFS_NV_WRITE && nv_timer_reg != 16'h0000) begin
			nv_timer_reg <= nv_timer_reg - 16'h0001;
		end
	end

	// Persistent copy; bits 1:0 are never written
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			persist_reg <= {`SFS_FIELD_RESET, `SFS_WEL_DEFAULT, `SFS_BUSY_DEFAULT};
		end else if (nv_finish) begin
			persist_reg[`SFS_BIT_LOCK:`SFS_BIT_BP_LO] <= nv_pend_reg; // RULE1 RULE2
		end
	end

	// Live lock, side and protect field
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			field_reg <= `SFS_FIELD_RESET; // RULE21
		end else if (soft_rst) begin
			field_reg <= persist_reg[`SFS_BIT_LOCK:`SFS_BIT_BP_LO]; // RULE21
		end else if (nv_finish) begin
			field_reg <= nv_pend_reg; // RULE6
		end else if (live_wr) begin
			field_reg <= wr_field;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wel_reg <= `SFS_WEL_DEFAULT; // RULE14
		end else if (soft_rst) begin
			wel_reg <= persist_reg[`SFS_BIT_WEL]; // RULE14
		end else if (clr_wel || clear_status_cmd) begin
			wel_reg <= 1'b0; // RULE11
		end else if (set_wel) begin
			wel_reg <= 1'b1; // RULE11
		end else if (nv_finish || live_wr || (arr_finish && !op_fail_i)) begin
			wel_reg <= 1'b0; // RULE12
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			vol_mode_reg <= 1'b0;
			arm_reg <= 1'b0;
		end else begin
			if (soft_rst || vol_off) begin
				vol_mode_reg <= 1'b0;
			end else if (vol_on) begin
				vol_mode_reg <= 1'b1;
			end
			if (frame_end) begin
				arm_reg <= opcode_reg == `SFS_OP_RESET_ARM; // RULE17
			end
		end
	end

	// Error flags; a failure in the clearing cycle still sets
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			erase_error_o <= 1'b0;
			program_error_o <= 1'b0;
		end else if (arr_finish && op_fail_i) begin
			erase_error_o <= arr_erase_reg | (erase_error_o & ~clear_status_cmd);
			program_error_o <= ~arr_erase_reg | (program_error_o & ~clear_status_cmd);
		end else if (clear_status_cmd || soft_rst) begin
			erase_error_o <= 1'b0; // RULE23
			program_error_o <= 1'b0; // RULE23
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			arr_erase_reg <= 1'b0;
			array_start_o <= 1'b0;
			array_is_erase_o <= 1'b0;
			suspend_o <= 1'b0;
		end else begin
			array_start_o <= start_arr;
			suspend_o <= susp;
			if (start_arr) begin
				arr_erase_reg <= arr_erase;
				array_is_erase_o <= arr_erase;
			end
		end
	end

	assign write_enable_latch_o = wel_reg;
	assign register_lock_bit_o = field_reg[5];
	assign top_bottom_ref_o = field_reg[4]; // RULE8
	assign block_protect_field_o = field_reg[3:0]; // RULE9
	assign status_byte = {field_reg, wel_reg, busy_o};

	// Publish live status to the link side
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pub_req_reg <= 1'b0;
			pub_data_reg <= `SFS_STATUS_RESET;
		end else if (ack_s2 == pub_req_reg && status_byte != pub_data_reg) begin
			pub_data_reg <= status_byte; // RULE22
			pub_req_reg <= ~pub_req_reg;
		end
	end

	property p_locked_write;
		@(posedge clock_i) disable iff (!reset_n_i)
		frame_end && locked && !busy && opcode_reg == `SFS_OP_WR_REGS
			|=> $stable(field_reg) && $stable(persist_reg) && !busy_o;
	endproperty
	a_locked_write: assert property (p_locked_write) else $error("locked write took effect"); // RULE3

	property p_wel_cause;
		@(posedge clock_i) disable iff (!reset_n_i)
		$rose(wel_reg) |-> $past(frame_end) && ($past(opcode_reg) == `SFS_OP_PERSIST_WE ||
			$past(opcode_reg) == `SFS_OP_LIVE_WE || $past(opcode_reg) == `SFS_OP_RESET_GO);
	endproperty
	a_wel_cause: assert property (p_wel_cause) else $error("latch set without command"); // RULE11

	property p_wel_success;
		@(posedge clock_i) disable iff (!reset_n_i)
		arr_finish && !op_fail_i && !frame_end |=> !wel_reg && !busy_o;
	endproperty
	a_wel_success: assert property (p_wel_success) else $error("latch kept after success"); // RULE12

	property p_start_needs_wel;
		@(posedge clock_i) disable iff (!reset_n_i)
		$rose(busy_o) |-> $past(wel_reg);
	endproperty
	a_start_needs_wel: assert property (p_start_needs_wel) else $error("start without latch"); // RULE10

	property p_error_holds;
		@(posedge clock_i) disable iff (!reset_n_i)
		(erase_error_o || program_error_o) && state_reg == SFS_ERROR && !clear_status_cmd && !soft_rst
			|-> busy_o [*2];
	endproperty
	a_error_holds: assert property (p_error_holds) else $error("busy dropped with error"); // RULE19

	property p_suspend_gate;
		@(posedge clock_i) disable iff (!reset_n_i)
		suspend_o |-> $past(state_reg) == SFS_ARRAY;
	endproperty
	a_suspend_gate: assert property (p_suspend_gate) else $error("suspend outside array op"); // RULE18

	property p_busy_ignore;
		@(posedge clock_i) disable iff (!reset_n_i)
		frame_end && busy && !nv_finish && !arr_finish && !clear_status_cmd &&
			(opcode_reg == `SFS_OP_PERSIST_WE || opcode_reg == `SFS_OP_WR_DISABLE)
			|=> $stable(wel_reg);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy"); // RULE17

	property p_follow_persist;
		@(posedge clock_i) disable iff (!reset_n_i)
		nv_finish && !soft_rst |=> field_reg == persist_reg[7:2] && !busy_o;
	endproperty
	a_follow_persist: assert property (p_follow_persist) else $error("live bits not updated"); // RULE6

	property p_factory_bits;
		@(posedge clock_i) disable iff (!reset_n_i)
		##1 $stable(persist_reg[1:0]);
	endproperty
	a_factory_bits: assert property (p_factory_bits) else $error("factory bits changed"); // RULE2

	property p_quad_unlock;
		@(posedge clock_i) disable iff (!reset_n_i)
		frame_end && (quad_command_mode_i || quad_io_i) &&
			opcode_reg == `SFS_OP_WR_REGS && nbytes_reg >= 3'd2 &&
			wel_reg && !busy && !vol_mode_reg |=> busy_o;
	endproperty
	a_quad_unlock: assert property (p_quad_unlock) else $error("quad mode left lock active"); // RULE7

endmodule

//--- testbench/sfs_host_model.sv
`timescale 1ns/1ps
module sfs_host_model (
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i,
	input wire logic so_oe_n_i
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	// Link clock stands still low outside frames
	task automatic open_frame();
		#(40 + ($urandom() % 4)) cs_n_o = 1'b0;
		#10;
	endtask
	// Mode 0: data set while clock low, reply taken on rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic oe_ok);
		oe_ok = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			si_o = tx[i];
			#15 sck_o = 1'b1;
			rx[i] = so_i;
			oe_ok = oe_ok & (so_oe_n_i === 1'b0);
			#15 sck_o = 1'b0;
		end
	endtask
	// Released data line toggles so no stale level is seen
	task automatic close_frame();
		#10 cs_n_o = 1'b1;
		si_o = ~si_o;
	endtask
endmodule

//--- testbench/serial_flash_status_reg_one_bench.sv
`timescale 1ns/1ps
module serial_flash_status_reg_one_bench;
	logic clock_i;
	logic reset_n_i;
	logic wp_n_i, qcm_i, qio_i, op_done_i, op_fail_i;
	logic sck, cs_n, si, so, so_oe_n;
	logic busy, write_enable_latch, lock, tb, a_start, a_erase, susp, e_err, p_err;
	logic [3:0] bp;
	int fails = 0;
	int tests_run = 0;
	int n_start = 0;
	int n_susp = 0;
	logic [5:0] m_live, m_nv;
	logic m_wel;

	sfs_status_one #(.NV_WRITE_CYCLES(16'h0040)) i_dut (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
		.wp_n_i(wp_n_i), .quad_command_mode_i(qcm_i), .quad_io_i(qio_i),
		.op_done_i(op_done_i), .op_fail_i(op_fail_i), .so_o(so), .so_oe_n_o(so_oe_n),
		.busy_o(busy), .write_enable_latch_o(write_enable_latch), .register_lock_bit_o(lock),
		.top_bottom_ref_o(tb), .block_protect_field_o(bp), .array_start_o(a_start),
		.array_is_erase_o(a_erase), .suspend_o(susp), .erase_error_o(e_err),
		.program_error_o(p_err)
	);
	sfs_host_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_n_i(so_oe_n));

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	// Count one-cycle pulses
	always @(posedge clock_i) begin
		if (a_start === 1'b1) n_start++;
		if (susp === 1'b1) n_susp++;
	end

	function automatic logic [7:0] stat_of(input logic [5:0] f, input logic w, input logic b);
		return {f, w, b};
	endfunction
	function automatic logic may_write(input logic l, input logic w, input logic q, input logic o);
		return !l || w || q || o;
	endfunction

	task automatic chk_bit(input string what, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic chk_live();
		chk_byte("live field", {2'b00, m_live}, {2'b00, lock, tb, bp});
		chk_bit("latch", m_wel, write_enable_latch);
		chk_bit("busy", 1'b0, busy);
	endtask
	task automatic cmd(input logic [7:0] op);
		logic [7:0] r;
		logic ok;
		host.open_frame();
		host.xfer(op, r, ok);
		host.close_frame();
		tick(8);
	endtask
	task automatic cmd_d(input logic [7:0] op, input logic [7:0] d);
		logic [7:0] r;
		logic ok;
		host.open_frame();
		host.xfer(op, r, ok);
		host.xfer(d, r, ok);
		host.close_frame();
		tick(8);
	endtask
	task automatic wr_any(input logic [23:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic ok;
		host.open_frame();
		host.xfer(8'h71, r, ok);
		host.xfer(a[23:16], r, ok);
		host.xfer(a[15:8], r, ok);
		host.xfer(a[7:0], r, ok);
		host.xfer(d, r, ok);
		host.close_frame();
		tick(8);
	endtask
	// Status mirror refreshes on link edges, so the third byte is judged
	task automatic rd(input logic [7:0] op, input logic [23:0] a, output logic [7:0] r);
		logic ok;
		logic all_ok;
		host.open_frame();
		host.xfer(op, r, ok);
		if (op == 8'h65) begin
			host.xfer(a[23:16], r, ok);
			host.xfer(a[15:8], r, ok);
			host.xfer(a[7:0], r, ok);
		end
		all_ok = 1'b1;
		for (int i = 0; i < 3; i++) begin
			host.xfer(8'hFF, r, ok);
			all_ok = all_ok & ok;
		end
		host.close_frame();
		tick(8);
		chk_bit("read drive", 1'b1, all_ok);
		chk_bit("idle enable", 1'b1, so_oe_n);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 400) begin
			tick(1);
			n++;
		end
		chk_bit("idle wait", 1'b0, busy);
	endtask
	task automatic op_end(input logic f);
		@(posedge clock_i);
		#1 op_done_i = 1'b1;
		op_fail_i = f;
		@(posedge clock_i);
		#1 op_done_i = 1'b0;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		#400000;
		fails++;
		wrap_up();
	end

	initial begin
		logic [7:0] d, r;
		reset_n_i = 1'b0;
		wp_n_i = 1'b1;
		qcm_i = 1'b0;
		qio_i = 1'b0;
		op_done_i = 1'b0;
		op_fail_i = 1'b0;
		m_live = 6'h00;
		m_nv = 6'h00;
		m_wel = 1'b0;
		void'($urandom(55902));
		repeat (16) @(posedge clock_i);
		#1 reset_n_i = 1'b1;
		tick(4);
		chk_live();
		rd(8'h05, 24'h000000, r);
		chk_byte("status read", stat_of(m_live, 1'b0, 1'b0), r);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom()) | 8'h03;
			cmd(8'h06);
			chk_bit("latch set", 1'b1, write_enable_latch);
			cmd_d(8'h01, d);
			chk_bit("busy writing", 1'b1, busy);
			wait_idle();
			m_live = d[7:2];
			m_nv = d[7:2];
			chk_live();
			rd(8'h05, 24'h000000, r);
			chk_byte("status read", stat_of(m_live, 1'b0, 1'b0), r);
		end
		cmd_d(8'h01, ~d);
		chk_live();
		$display("test persistent write done");
		cmd(8'h50);
		chk_bit("latch live", 1'b1, write_enable_latch);
		d = 8'($urandom());
		cmd_d(8'h01, d);
		m_live = d[7:2];
		chk_live();
		rd(8'h65, 24'h800000, r);
		chk_byte("read any live", stat_of(m_live, 1'b0, 1'b0), r);
		rd(8'h65, 24'h000000, r);
		chk_byte("read any persistent", stat_of(m_live, 1'b0, 1'b0), r);
		cmd(8'h06);
		cmd(8'h04);
		chk_live();
		cmd(8'h66);
		cmd(8'h99);
		m_live = m_nv;
		chk_live();
		$display("test latch done");
		cmd(8'h06);
		d = 8'($urandom());
		wr_any(24'h800000, d);
		m_live = d[7:2];
		chk_live();
		cmd(8'h06);
		wr_any(24'h123456, ~d);
		chk_bit("bad address latch", 1'b1, write_enable_latch);
		wr_any(24'h000000, d ^ 8'h3C);
		wait_idle();
		m_live = d[7:2] ^ 6'h0F;
		m_nv = m_live;
		chk_live();
		$display("test write any done");
		for (int i = 1; i <= 8; i++) begin
			d = {1'b1, 5'($urandom()), 2'b00};
			@(posedge clock_i);
			#1 {wp_n_i, qcm_i, qio_i} = 3'(i);
			tick(4);
			cmd(8'h06);
			cmd_d(8'h01, d);
			wait_idle();
			if (may_write(m_live[5], wp_n_i, qcm_i, qio_i)) begin
				m_live = d[7:2];
				m_nv = d[7:2];
			end
			chk_byte("locked field", {2'b00, m_live}, {2'b00, lock, tb, bp});
			cmd(8'h04);
		end
		$display("test lock done");
		cmd(8'h75);
		chk_byte("suspend idle", 8'h00, 8'(n_susp));
		cmd(8'h02);
		chk_byte("start no latch", 8'h00, 8'(n_start));
		cmd(8'h06);
		cmd(8'h02);
		chk_byte("start", 8'h01, 8'(n_start));
		chk_bit("erase kind", 1'b0, a_erase);
		cmd(8'h75);
		chk_byte("suspend", 8'h01, 8'(n_susp));
		cmd(8'h04);
		chk_bit("busy latch", 1'b1, write_enable_latch);
		op_end(1'b1);
		tick(4);
		chk_bit("program error", 1'b1, p_err);
		tick(40);
		chk_bit("held busy", 1'b1, busy);
		cmd(8'h30);
		chk_bit("errors cleared", 1'b0, p_err | busy | write_enable_latch);
		cmd(8'h06);
		cmd(8'h20);
		chk_bit("erase kind", 1'b1, a_erase);
		op_end(1'b1);
		tick(4);
		chk_bit("erase error", 1'b1, e_err);
		cmd(8'h66);
		cmd(8'h99);
		chk_bit("reset clears", 1'b0, e_err | busy);
		cmd(8'h06);
		cmd(8'h60);
		chk_bit("chip erase busy", 1'b1, busy);
		op_end(1'b0);
		tick(4);
		chk_live();
		chk_byte("starts", 8'h03, 8'(n_start));
		$display("test array done");
		wrap_up();
	end
endmodule
